/* core/lp_device.sv */
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/10ps
// Overview of operation
// [RULE1] Host marks command bytes with bit 7
// [RULE2] Bits 6:5 pick transaction type
// [RULE3] Repeated-byte keeps the same register
// [RULE4] Auto-increment advances pointer per data byte
// [RULE5] Bits 4:0 latch as register pointer
// [RULE6] Special codes clear proximity/light interrupts
// [RULE7] Interrupt clear releases by itself
// [RULE8] Host writes enable bits 7:6 zero
// [RULE9] Proximity interrupt only when its mask set
// [RULE10] Light interrupt only when its mask set
// [RULE11] Wait bit enables the wait timer
// [RULE12] Proximity bit enables proximity function
// [RULE13] Light bit enables light converter
// [RULE14] Power bit runs the internal oscillator
// [RULE15] One step hold-off after power on
// [RULE16] Light steps equal 256 minus setting
// [RULE17] Proximity steps same; 1023 per step
// [RULE18] Host should program one proximity step
// [RULE19] Light 1024 per step, saturates 65535
// [RULE20] Read without command uses stored pointer
// [RULE21] Interrupt stays until matching clear
module lp_device #(
  parameter int STEP_CYC = lp_pkg::STEP_CYCLES
) (
  input wire logic mclk,
  input wire logic rst,
  lp_link_if.dev link,
  input wire logic light_pulse,
  input wire logic prox_pulse,
  output logic osc_run,
  output logic light_adc_run,
  output logic prox_run,
  output logic wait_run
);
  typedef enum logic [2:0] {st_sleep, st_warm, st_prox, st_wait, st_light} meas_e;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] enable_ff, light_time_ff, prox_time_ff;
  logic [4:0] ptr_ff;
  logic [1:0] type_ff;
  logic first_ff;
  logic [7:0] rd_byte_ff;
  logic rd_ack_ff;
  logic prox_int_ff, light_int_ff;
  logic [15:0] light_data_ff, prox_data_ff, light_acc_ff, prox_acc_ff;
  logic [10:0] step_hits_ff;
  logic [31:0] tick_cnt_ff;
  logic [8:0] steps_left_ff;
  meas_e state_ff;
  logic [2:0] lsync_ff, psync_ff;

  // ----------------------------------------
  // Link decode
  // ----------------------------------------
  wire is_cmd = link.wr_stb && first_ff && link.wr_byte[lp_pkg::CMD_SEL_BIT]; // see [RULE1]
  wire [1:0] cmd_type = link.wr_byte[lp_pkg::TYPE_HI:lp_pkg::TYPE_LO]; // see [RULE2]
  wire [4:0] cmd_addr = link.wr_byte[lp_pkg::ADDR_HI:0];
  wire is_special = is_cmd && cmd_type == lp_pkg::TYPE_SPECIAL;
  wire data_wr = link.wr_stb && !is_cmd;
  wire data_acc = data_wr || link.rd_stb;
  // Pulses last one cycle only, so the clear never needs a release write
  wire clr_prox = is_special && (cmd_addr == lp_pkg::SF_CLR_PROX ||
    cmd_addr == lp_pkg::SF_CLR_BOTH); // see [RULE6] [RULE7]
  wire clr_light = is_special && (cmd_addr == lp_pkg::SF_CLR_LIGHT ||
    cmd_addr == lp_pkg::SF_CLR_BOTH); // see [RULE6] [RULE7]
  // Reserved type 2 is treated like repeated-byte: pointer left still
  wire adv_ptr = data_acc && type_ff == lp_pkg::TYPE_AUTOINC; // see [RULE3] [RULE4]
  wire [4:0] nxt_ptr = (is_cmd && !is_special) ? cmd_addr : // see [RULE5]
    adv_ptr ? ptr_ff + 5'h01 : ptr_ff; // see [RULE20]

  function automatic logic [7:0] read_mux(input logic [4:0] a, input logic [7:0] en,
      input logic [7:0] lt, input logic [7:0] pt, input logic [7:0] st,
      input logic [15:0] ld, input logic [15:0] pd);
    logic [7:0] r;
    r = 8'h00;
    case (a)
      lp_pkg::REG_FUNCTION_ENABLE: r = en;
      lp_pkg::REG_LIGHT_INTEG_TIME: r = lt;
      lp_pkg::REG_PROX_INTEG_TIME: r = pt;
      lp_pkg::REG_STATUS: r = st;
      lp_pkg::REG_LIGHT_LO: r = ld[7:0];
      lp_pkg::REG_LIGHT_HI: r = ld[15:8];
      lp_pkg::REG_PROX_LO: r = pd[7:0];
      lp_pkg::REG_PROX_HI: r = pd[15:8];
      default: r = 8'h00;
    endcase
    return r;
  endfunction

  wire [7:0] status_byte = {2'h0, prox_int_ff, light_int_ff, 1'b0, state_ff};
  wire [7:0] rd_val = read_mux(ptr_ff, enable_ff, light_time_ff, prox_time_ff,
    status_byte, light_data_ff, prox_data_ff); // see [RULE20]

  // ----------------------------------------
  // Link handling
  // ----------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ptr_ff <= 5'h00;
      type_ff <= lp_pkg::TYPE_REPEAT;
      first_ff <= 1'b0;
      rd_ack_ff <= 1'b0;
      rd_byte_ff <= 8'h00;
    end else begin
      ptr_ff <= nxt_ptr;
      if (is_cmd) begin
        type_ff <= cmd_type; // see [RULE2]
      end
      first_ff <= link.start ? 1'b1 : (link.wr_stb || link.rd_stb) ? 1'b0 : first_ff;
      rd_ack_ff <= link.rd_stb;
      if (link.rd_stb) begin
        rd_byte_ff <= rd_val;
      end
    end
  end

  wire wr_en = data_wr && ptr_ff == lp_pkg::REG_FUNCTION_ENABLE;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      enable_ff <= lp_pkg::ENABLE_RESET;
      light_time_ff <= lp_pkg::INTEG_RESET;
      prox_time_ff <= lp_pkg::INTEG_RESET;
    end else begin
      // Reserved bits kept zero whatever the host sends
      if (wr_en) begin
        enable_ff <= link.wr_byte & lp_pkg::ENABLE_WMASK; // see [RULE8]
      end
      if (data_wr && ptr_ff == lp_pkg::REG_LIGHT_INTEG_TIME) begin
        light_time_ff <= link.wr_byte;
      end
      if (data_wr && ptr_ff == lp_pkg::REG_PROX_INTEG_TIME) begin
        prox_time_ff <= link.wr_byte;
      end
    end
  end

  // ----------------------------------------
  // Photon pulse synchronisers
  // ----------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      lsync_ff <= 3'h0;
      psync_ff <= 3'h0;
    end else begin
      lsync_ff <= {lsync_ff[1:0], light_pulse};
      psync_ff <= {psync_ff[1:0], prox_pulse};
    end
  end
  wire light_hit = lsync_ff[1] && !lsync_ff[2];
  wire prox_hit = psync_ff[1] && !psync_ff[2];

  // ----------------------------------------
  // Measurement sequencer
  // ----------------------------------------
  wire osc_on = enable_ff[lp_pkg::EN_OSC]; // see [RULE14]
  wire step_end = tick_cnt_ff == STEP_CYC - 1;
  wire phase_end = step_end && steps_left_ff == 9'h001;
  wire [8:0] light_steps = 9'h100 - {1'b0, light_time_ff}; // see [RULE16]
  wire [8:0] prox_steps = 9'h100 - {1'b0, prox_time_ff}; // see [RULE17]
  wire prox_on = enable_ff[lp_pkg::EN_PROX]; // see [RULE12]
  wire wait_on = enable_ff[lp_pkg::EN_WAIT]; // see [RULE11]
  wire light_on = enable_ff[lp_pkg::EN_LIGHT]; // see [RULE13]
  wire [10:0] step_cap = state_ff == st_light ? lp_pkg::LIGHT_STEP_MAX :
    lp_pkg::PROX_STEP_MAX;
  wire hit = (state_ff == st_light) ? light_hit : prox_hit;
  wire take_hit = hit && step_hits_ff < step_cap; // see [RULE17] [RULE19]
  wire end_prox = state_ff == st_prox && prox_on && phase_end;
  wire end_light = state_ff == st_light && phase_end;

  meas_e nxt_state;
  logic [8:0] nxt_steps;
  always_comb begin
    nxt_state = state_ff;
    nxt_steps = steps_left_ff;
    if (state_ff != st_sleep && step_end) begin
      nxt_steps = steps_left_ff - 9'h001;
    end
    unique case (state_ff)
      st_sleep: begin
        if (osc_on) begin
          nxt_state = st_warm;
          nxt_steps = 9'h001; // see [RULE15]
        end
      end
      st_warm, st_prox, st_wait, st_light: begin
        if (phase_end) begin
          if (state_ff == st_warm || state_ff == st_light) begin
            nxt_state = prox_on ? st_prox : wait_on ? st_wait : st_light;
          end else if (state_ff == st_prox) begin
            nxt_state = wait_on ? st_wait : st_light;
          end else begin
            nxt_state = st_light;
          end
          nxt_steps = nxt_state == st_prox ? prox_steps :
            nxt_state == st_light ? light_steps : 9'h001;
          if (nxt_state == st_light && !light_on) begin
            // Idle light phase still paces the loop
            nxt_steps = 9'h001;
          end
        end
      end
    endcase
    if (!osc_on) begin
      nxt_state = st_sleep; // see [RULE14]
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_ff <= st_sleep;
      steps_left_ff <= 9'h000;
      tick_cnt_ff <= 32'h0;
    end else begin
      state_ff <= nxt_state;
      steps_left_ff <= nxt_steps;
      tick_cnt_ff <= (state_ff == st_sleep || step_end) ? 32'h0 : tick_cnt_ff + 32'h1;
    end
  end

  // ----------------------------------------
  // Accumulators and interrupts
  // ----------------------------------------
  wire in_meas = (state_ff == st_prox && prox_on) || (state_ff == st_light && light_on);
  wire [15:0] acc_cur = state_ff == st_light ? light_acc_ff : prox_acc_ff;
  wire [15:0] acc_nxt = (take_hit && acc_cur != 16'hFFFF) ? acc_cur + 16'h0001 :
    acc_cur; // see [RULE19]

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      step_hits_ff <= 11'h000;
      light_acc_ff <= 16'h0000;
      prox_acc_ff <= 16'h0000;
      light_data_ff <= 16'h0000;
      prox_data_ff <= 16'h0000;
    end else begin
      step_hits_ff <= (step_end || !in_meas) ? 11'h000 :
        take_hit ? step_hits_ff + 11'h001 : step_hits_ff;
      if (state_ff == st_light && light_on) begin
        light_acc_ff <= phase_end ? 16'h0000 : acc_nxt;
      end
      if (state_ff == st_prox && prox_on) begin
        prox_acc_ff <= phase_end ? 16'h0000 : acc_nxt;
      end
      if (end_light && light_on) begin
        light_data_ff <= acc_nxt;
      end
      if (end_prox) begin
        prox_data_ff <= acc_nxt;
      end
    end
  end

  // Set beats clear in the same cycle so no event is lost
  wire set_prox = end_prox && enable_ff[lp_pkg::EN_PROX_IRQ]; // see [RULE9]
  wire set_light = end_light && light_on && enable_ff[lp_pkg::EN_LIGHT_IRQ]; // see [RULE10]
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prox_int_ff <= 1'b0;
      light_int_ff <= 1'b0;
    end else begin
      prox_int_ff <= set_prox || (prox_int_ff && !clr_prox); // see [RULE21]
      light_int_ff <= set_light || (light_int_ff && !clr_light); // see [RULE21]
    end
  end

  assign link.rd_ack = rd_ack_ff;
  assign link.rd_byte = rd_byte_ff;
  assign link.irq = prox_int_ff || light_int_ff;
  assign osc_run = osc_on;
  assign light_adc_run = state_ff == st_light && light_on;
  assign prox_run = state_ff == st_prox && prox_on; // see [RULE12]
  assign wait_run = state_ff == st_wait && wait_on; // see [RULE11]
endmodule

/* core/lp_host.sv */
`timescale 1ns/10ps
module lp_host (
  input wire logic mclk,
  input wire logic rst,
  lp_link_if.host link,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  typedef enum logic [1:0] {hs_idle, hs_start, hs_xfer, hs_wait} host_e;

  // ----------------------------------------
  // AXI4-Lite write side
  // ----------------------------------------
  logic aw_ff, w_ff, bvalid_ff, rvalid_ff, err_ff, busy_q;
  logic [3:0] awaddr_ff;
  logic [31:0] wdata_ff, rdata_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [10:0] op_ff;
  logic [7:0] rd_keep_ff;
  logic [4:0] ptr_ff;
  logic [1:0] type_ff;
  host_e state_ff;

  wire aw_take = s_axi_awvalid && !aw_ff && !bvalid_ff;
  wire w_take = s_axi_wvalid && !w_ff && !bvalid_ff;
  wire both = aw_ff && w_ff;
  wire op_hit = awaddr_ff == lp_pkg::HOST_OP;
  wire [1:0] op_kind = wdata_ff[9:8];
  wire [7:0] op_byte = wdata_ff[7:0];
  // Host always marks command bytes and keeps reserved codes off the wire
  wire [7:0] cmd_byte = op_byte | 8'h80; // see [RULE1]
  wire bad_type = op_kind == lp_pkg::OP_CMD &&
    op_byte[lp_pkg::TYPE_HI:lp_pkg::TYPE_LO] == lp_pkg::TYPE_RESERVED; // see [RULE2]
  wire bad_sf = op_kind == lp_pkg::OP_CMD &&
    op_byte[lp_pkg::TYPE_HI:lp_pkg::TYPE_LO] == lp_pkg::TYPE_SPECIAL &&
    !(op_byte[4:0] == lp_pkg::SF_NONE || op_byte[4:0] == lp_pkg::SF_CLR_PROX ||
    op_byte[4:0] == lp_pkg::SF_CLR_LIGHT || op_byte[4:0] == lp_pkg::SF_CLR_BOTH); // see [RULE6]
  wire bad_kind = op_kind == 2'h3;
  wire op_ok = op_hit && !busy_q && !bad_type && !bad_sf && !bad_kind;
  wire launch = both && !bvalid_ff && op_ok;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      aw_ff <= 1'b0;
      w_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= lp_pkg::RESP_OKAY;
      awaddr_ff <= 4'h0;
      wdata_ff <= 32'h0;
    end else begin
      if (aw_take) begin
        aw_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (w_take) begin
        w_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
      end
      if (both && !bvalid_ff) begin
        bvalid_ff <= 1'b1;
        bresp_ff <= op_ok ? lp_pkg::RESP_OKAY : lp_pkg::RESP_SLVERR;
        aw_ff <= 1'b0;
        w_ff <= 1'b0;
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Link sequencer
  // ----------------------------------------
  wire is_rd = op_ff[9:8] == lp_pkg::OP_READ;
  wire is_cmd = op_ff[9:8] == lp_pkg::OP_CMD;
  // Enable register reserved bits forced to zero on data writes
  wire [7:0] data_byte = ptr_ff == lp_pkg::REG_FUNCTION_ENABLE ?
    op_ff[7:0] & lp_pkg::ENABLE_WMASK : op_ff[7:0]; // see [RULE8]
  wire xfer = state_ff == hs_xfer;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_ff <= hs_idle;
      op_ff <= 11'h000;
      rd_keep_ff <= 8'h00;
      ptr_ff <= 5'h00;
      type_ff <= lp_pkg::TYPE_REPEAT;
      err_ff <= 1'b0;
    end else begin
      if (both && !bvalid_ff && op_hit) begin
        err_ff <= !op_ok;
      end
      unique case (state_ff)
        hs_idle: begin
          if (launch) begin
            op_ff <= {wdata_ff[lp_pkg::OP_START_BIT], op_kind, is_cmd_byte(op_kind, cmd_byte,
              op_byte)};
            state_ff <= wdata_ff[lp_pkg::OP_START_BIT] ? hs_start : hs_xfer;
          end
        end
        hs_start: state_ff <= hs_xfer;
        hs_xfer: begin
          state_ff <= is_rd ? hs_wait : hs_idle;
          if (is_cmd) begin
            type_ff <= op_ff[6:5];
            if (op_ff[6:5] != lp_pkg::TYPE_SPECIAL) begin
              ptr_ff <= op_ff[4:0];
            end
          end else if (type_ff == lp_pkg::TYPE_AUTOINC) begin
            ptr_ff <= ptr_ff + 5'h01;
          end
        end
        hs_wait: begin
          if (link.rd_ack) begin
            rd_keep_ff <= link.rd_byte;
            state_ff <= hs_idle;
          end
        end
      endcase
    end
  end

  function automatic logic [7:0] is_cmd_byte(input logic [1:0] k, input logic [7:0] c,
      input logic [7:0] d);
    return k == lp_pkg::OP_CMD ? c : d;
  endfunction

  assign busy_q = state_ff != hs_idle;
  assign link.start = state_ff == hs_start;
  assign link.wr_stb = xfer && !is_rd;
  assign link.wr_byte = is_cmd ? op_ff[7:0] : data_byte;
  assign link.rd_stb = xfer && is_rd;

  // ----------------------------------------
  // AXI4-Lite read side
  // ----------------------------------------
  wire ar_take = s_axi_arvalid && !rvalid_ff;
  wire [31:0] rd_mux = s_axi_araddr == lp_pkg::HOST_STATUS ?
    {28'h0, err_ff, link.irq, busy_q || launch, 1'b0} :
    s_axi_araddr == lp_pkg::HOST_RDATA ? {24'h0, rd_keep_ff} :
    s_axi_araddr == lp_pkg::HOST_OP ? {21'h0, op_ff} : 32'h0;
  wire ar_ok = s_axi_araddr == lp_pkg::HOST_STATUS || s_axi_araddr == lp_pkg::HOST_RDATA ||
    s_axi_araddr == lp_pkg::HOST_OP;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0;
      rresp_ff <= lp_pkg::RESP_OKAY;
    end else begin
      if (ar_take) begin
        rvalid_ff <= 1'b1;
        rdata_ff <= rd_mux;
        rresp_ff <= ar_ok ? lp_pkg::RESP_OKAY : lp_pkg::RESP_SLVERR;
      end else if (rvalid_ff && s_axi_rready) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  assign s_axi_awready = !aw_ff && !bvalid_ff;
  assign s_axi_wready = !w_ff && !bvalid_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
endmodule

/* core/lp_link_if.sv */
`timescale 1ns/10ps
interface lp_link_if;
  logic start;
  logic wr_stb;
  logic [7:0] wr_byte;
  logic rd_stb;
  logic rd_ack;
  logic [7:0] rd_byte;
  logic irq;
  modport dev (input start, input wr_stb, input wr_byte, input rd_stb,
    output rd_ack, output rd_byte, output irq);
  modport host (output start, output wr_stb, output wr_byte, output rd_stb,
    input rd_ack, input rd_byte, input irq);
endinterface

/* core/lp_pkg.sv */
package lp_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int STEP_TIME_NS = 2720000;
  localparam int STEP_CYCLES = (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------
  // Command byte layout
  // ----------------------------------------
  localparam int CMD_SEL_BIT = 7;
  localparam int TYPE_HI = 6;
  localparam int TYPE_LO = 5;
  localparam int ADDR_HI = 4;
  localparam logic [1:0] TYPE_REPEAT = 2'h0;
  localparam logic [1:0] TYPE_AUTOINC = 2'h1;
  localparam logic [1:0] TYPE_RESERVED = 2'h2;
  localparam logic [1:0] TYPE_SPECIAL = 2'h3;
  localparam logic [4:0] SF_NONE = 5'h00;
  localparam logic [4:0] SF_CLR_PROX = 5'h05;
  localparam logic [4:0] SF_CLR_LIGHT = 5'h06;
  localparam logic [4:0] SF_CLR_BOTH = 5'h07;

  // ----------------------------------------
  // Device register map
  // ----------------------------------------
  localparam logic [4:0] REG_FUNCTION_ENABLE = 5'h00;
  localparam logic [4:0] REG_LIGHT_INTEG_TIME = 5'h01;
  localparam logic [4:0] REG_PROX_INTEG_TIME = 5'h02;
  localparam logic [4:0] REG_STATUS = 5'h13;
  localparam logic [4:0] REG_LIGHT_LO = 5'h14;
  localparam logic [4:0] REG_LIGHT_HI = 5'h15;
  localparam logic [4:0] REG_PROX_LO = 5'h18;
  localparam logic [4:0] REG_PROX_HI = 5'h19;
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [7:0] INTEG_RESET = 8'hFF;
  localparam logic [7:0] ENABLE_WMASK = 8'h3F;
  localparam int EN_PROX_IRQ = 5;
  localparam int EN_LIGHT_IRQ = 4;
  localparam int EN_WAIT = 3;
  localparam int EN_PROX = 2;
  localparam int EN_LIGHT = 1;
  localparam int EN_OSC = 0;
  localparam logic [10:0] LIGHT_STEP_MAX = 11'h400;
  localparam logic [10:0] PROX_STEP_MAX = 11'h3FF;

  // ----------------------------------------
  // Host controller AXI4-Lite map
  // ----------------------------------------
  localparam logic [3:0] HOST_OP = 4'h0;
  localparam logic [3:0] HOST_STATUS = 4'h4;
  localparam logic [3:0] HOST_RDATA = 4'h8;
  localparam int OP_START_BIT = 10;
  localparam logic [1:0] OP_CMD = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* verification/lp_link_chk.sv */
`timescale 1ns/10ps
module lp_link_chk (
  input wire logic mclk,
  input wire logic rst,
  input wire logic start,
  input wire logic wr_stb,
  input wire logic [7:0] wr_byte,
  input wire logic rd_stb,
  input wire logic rd_ack,
  input wire logic [7:0] rd_byte,
  input wire logic irq
);
  logic clr_ff;
  default clocking dc @(posedge mclk); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // Link checks
  // ----------------------------------------
  // Clear command seen on the link; device may need one extra cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      clr_ff <= 1'b0;
    end else begin
      clr_ff <= wr_stb && (wr_byte[7:2] == 6'h39) && (wr_byte[1:0] != 2'h0);
    end
  end
  AST_RD_ACK: assert property (rd_stb |=> rd_ack)
    else $error("read not answered");
  AST_ACK_CAUSE: assert property (rd_ack |-> $past(rd_stb))
    else $error("ack without read");
  AST_RD_HOLD: assert property (!rd_ack |-> $stable(rd_byte))
    else $error("read byte moved");
  AST_CMD_MARK: assert property (start |=> wr_stb && wr_byte[7])
    else $error("command byte not marked");
  AST_NO_RESV: assert property ($past(start) && wr_stb |-> wr_byte[6:5] != 2'h2)
    else $error("reserved type sent");
  AST_SF_CODE: assert property ($past(start) && wr_stb && wr_byte[6:5] == 2'h3 |->
    wr_byte[4:0] inside {5'h00, 5'h05, 5'h06, 5'h07}) else $error("bad special code");
  AST_IRQ_CLEAR: assert property ($fell(irq) |-> clr_ff || $past(clr_ff))
    else $error("interrupt dropped without clear");
  AST_STB_PULSE: assert property (wr_stb |=> !wr_stb)
    else $error("write strobe too long");
  AST_ACK_PULSE: assert property (rd_ack |=> !rd_ack)
    else $error("ack too long");
  cover property (start ##1 wr_stb);
  cover property (rd_stb ##1 rd_ack);
  cover property ($rose(irq));
  cover property ($fell(irq));
endmodule

/* verification/tb.sv */
`timescale 1ns/10ps
module tb;
  localparam int S = 20;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic lp = 1'b0;
  logic pp = 1'b0;
  logic osc_run, light_adc_run, prox_run, wait_run;
  logic [3:0] awa = 4'h0, ara = 4'h0;
  logic awv = 1'b0, wv = 1'b0, brd = 1'b0, arv = 1'b0, rrd = 1'b0;
  logic [31:0] wd = 32'h0;
  logic awr, wr, bv, arr, rv, osc_q;
  logic [1:0] br, rr;
  logic [31:0] rd;
  int cyc = 0, t_on = 0, n, error_cnt = 0, checks = 0;
  lp_link_if link();
  lp_device #(.STEP_CYC(S)) lp_device_inst (.mclk(mclk), .rst(rst), .link(link),
    .light_pulse(lp), .prox_pulse(pp), .osc_run(osc_run), .light_adc_run(light_adc_run),
    .prox_run(prox_run), .wait_run(wait_run));
  lp_host lp_host_inst (.mclk(mclk), .rst(rst), .link(link), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv),
    .s_axi_bready(brd), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rrd));
  lp_link_chk lp_link_chk_inst (.mclk(mclk), .rst(rst), .start(link.start),
    .wr_stb(link.wr_stb), .wr_byte(link.wr_byte), .rd_stb(link.rd_stb),
    .rd_ack(link.rd_ack), .rd_byte(link.rd_byte), .irq(link.irq));
  always #20 mclk = ~mclk;
  always @(posedge mclk) begin
    lp <= ~lp;
    pp <= cyc[1];
    osc_q <= osc_run;
    cyc <= cyc + 1;
    if (osc_run && !osc_q) t_on <= cyc;
    if (cyc == 20000) begin
      error_cnt++;
      stop_test();
    end
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic stop_test();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge mclk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    brd <= 1'b1;
    while (1) begin
      @(posedge mclk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr) wv <= 1'b0;
      if (bv) begin
        r = br;
        brd <= 1'b0;
        break;
      end
    end
  endtask
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge mclk);
    ara <= a;
    arv <= 1'b1;
    rrd <= 1'b1;
    while (1) begin
      @(posedge mclk);
      if (arv && arr) arv <= 1'b0;
      if (rv) begin
        d = rd;
        r = rr;
        rrd <= 1'b0;
        break;
      end
    end
  endtask
  // Busy poll is bounded to 40 reads; the busy check after it catches a stuck host
  task automatic op(input logic [1:0] k, input logic st, input logic [7:0] b,
    input logic [1:0] er = lp_pkg::RESP_OKAY);
    logic [1:0] r;
    logic [31:0] d;
    axi_wr(lp_pkg::HOST_OP, {21'h0, st, k, b}, r);
    chk(32'(r), 32'(er));
    for (int i = 0; i < 40; i++) begin
      axi_rd(lp_pkg::HOST_STATUS, d, r);
      if (d[1] === 1'b0) break;
    end
    chk(32'(d[1]), 32'h0);
  endtask
  task automatic cmd(input logic [1:0] t, input logic [4:0] a,
    input logic [1:0] er = lp_pkg::RESP_OKAY);
    op(lp_pkg::OP_CMD, 1'b1, {1'b1, t, a}, er);
  endtask
  task automatic wrb(input logic [7:0] b);
    op(lp_pkg::OP_WRITE, 1'b0, b);
  endtask
  task automatic rdb(input logic [7:0] e);
    logic [1:0] r;
    logic [31:0] d;
    op(lp_pkg::OP_READ, 1'b0, 8'h00);
    axi_rd(lp_pkg::HOST_RDATA, d, r);
    chk(32'(d[7:0]), 32'(e));
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    chk(32'({osc_run, light_adc_run, prox_run, wait_run}), 32'h0);
    cmd(lp_pkg::TYPE_AUTOINC, lp_pkg::REG_LIGHT_INTEG_TIME);
    wrb(8'hFE);
    wrb(8'hFF);
    cmd(lp_pkg::TYPE_REPEAT, lp_pkg::REG_LIGHT_INTEG_TIME);
    rdb(8'hFE);
    rdb(8'hFE);
    cmd(lp_pkg::TYPE_AUTOINC, lp_pkg::REG_FUNCTION_ENABLE);
    rdb(8'h00);
    rdb(8'hFE);
    rdb(8'hFF);
    cmd(lp_pkg::TYPE_RESERVED, 5'h00, lp_pkg::RESP_SLVERR);
    cmd(lp_pkg::TYPE_SPECIAL, 5'h01, lp_pkg::RESP_SLVERR);
    axi_rd(lp_pkg::HOST_STATUS, d, r);
    chk(32'(d[3]), 32'h1);
    axi_rd(4'hC, d, r);
    chk({d[29:0], r}, {30'h0, lp_pkg::RESP_SLVERR});
    cmd(lp_pkg::TYPE_REPEAT, lp_pkg::REG_FUNCTION_ENABLE);
    wrb(8'hFF);
    for (n = 0; n < 400 && prox_run !== 1'b1; n++) @(posedge mclk);
    chk(32'(cyc - t_on >= S), 32'h1);
    chk(32'({osc_run, prox_run}), 32'h3);
    for (n = 0; n < 400 && wait_run !== 1'b1; n++) @(posedge mclk);
    chk(32'(wait_run), 32'h1);
    for (n = 0; n < 400 && light_adc_run !== 1'b1; n++) @(posedge mclk);
    for (n = 0; n < 400 && light_adc_run === 1'b1; n++) @(posedge mclk);
    chk(32'(n >= 2 * S && n <= 2 * S + 2), 32'h1);
    repeat (3) @(posedge mclk);
    chk(32'(link.irq), 32'h1);
    rdb(8'h3F);
    wrb(8'h01);
    repeat (2) @(posedge mclk);
    chk(32'({osc_run, light_adc_run, prox_run, wait_run}), 32'h8);
    chk(32'(link.irq), 32'h1);
    cmd(lp_pkg::TYPE_SPECIAL, lp_pkg::SF_CLR_BOTH);
    chk(32'(link.irq), 32'h0);
    wrb(8'h0F);
    repeat (300) @(posedge mclk);
    chk(32'(link.irq), 32'h0);
    wrb(8'h2F);
    for (n = 0; n < 400 && link.irq !== 1'b1; n++) @(posedge mclk);
    chk(32'(link.irq), 32'h1);
    wrb(8'h20);
    chk(32'(osc_run), 32'h0);
    cmd(lp_pkg::TYPE_SPECIAL, lp_pkg::SF_CLR_LIGHT);
    chk(32'(link.irq), 32'h1);
    cmd(lp_pkg::TYPE_SPECIAL, lp_pkg::SF_CLR_PROX);
    chk(32'(link.irq), 32'h0);
    cmd(lp_pkg::TYPE_SPECIAL, lp_pkg::SF_NONE);
    chk(32'(link.irq), 32'h0);
    // Light only, with its mask: warm-up, wait, then a two-step light phase
    wrb(8'h1B);
    for (n = 0; n < 400 && link.irq !== 1'b1; n++) @(posedge mclk);
    chk(32'(link.irq), 32'h1);
    cmd(lp_pkg::TYPE_SPECIAL, lp_pkg::SF_CLR_LIGHT);
    chk(32'(link.irq), 32'h0);
    stop_test();
  end
endmodule
